// >>> logic/serial_spi.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Operation
// RULE1 - uart bit plus mode field pick function
// RULE2 - uart_select high means uart, low spi/i2c
// RULE3 - modes 000/001/010: master, clock/4,/16,/64
// RULE4 - 011 sub clock master, 100 timer/2 master
// RULE5 - 101 slave, 110 i2c, 111 undefined
// RULE6 - mode field acts only with uart clear
// RULE7 - master alone starts transfers, drives clock
// RULE8 - full duplex: shift out while shifting in
// RULE9 - select pin enabled by bit, else floating
// RULE10 - software loads data before sending
// RULE11 - received byte readable in data register
// RULE12 - format and data reachable only in spi
// RULE13 - debounce field ignored outside i2c
// RULE14 - software routes pins, programs registers first
// RULE15 - module enable switches whole interface
// RULE16 - select released early: incomplete plus done
// RULE17 - exactly eight bits per transfer
// RULE18 - master clock derived, toggles only in transfer
module serial_spi #(
	parameter int BITS = 8
) (
	input  wire logic                            mclk,
	input  wire logic                            reset_n,
	input  wire logic [serial_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                            awvalid,
	output      logic                            awready,
	input  wire logic [31:0]                     wdata,
	input  wire logic [3:0]                      wstrb,
	input  wire logic                            wvalid,
	output      logic                            wready,
	output      logic [1:0]                      bresp,
	output      logic                            bvalid,
	input  wire logic                            bready,
	input  wire logic [serial_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                            arvalid,
	output      logic                            arready,
	output      logic [31:0]                     rdata,
	output      logic [1:0]                      rresp,
	output      logic                            rvalid,
	input  wire logic                            rready,
	input  wire logic                            sub_clock,
	input  wire logic                            timer_match,
	input  wire logic                            sck_i,
	output      logic                            sck_o,
	output      logic                            sck_oe,
	input  wire logic                            sdi,
	output      logic                            sdo,
	output      logic                            sdo_oe,
	input  wire logic                            slave_select_n_i,
	output      logic                            slave_select_n_o,
	output      logic                            slave_select_n_oe,
	output      logic                            irq
);
	// ************************************
	// state
	// ************************************
	serial_pkg::mode_ctl_s mc;          // mode control
	serial_pkg::fmt_ctl_s  fc;          // format control
	serial_pkg::xfer_e     st;          // master transfer state
	logic [7:0]            sh;          // shift data
	logic [2:0]            irq_en;      // event enables
	logic [5:0]            div_cnt;     // system clock divider
	logic [4:0]            edge_cnt;    // master clock edges
	logic [3:0]            bit_cnt;     // slave bits received
	logic                  sck_lvl;     // master clock level
	logic                  sub_q;       // sub clock edge detect
	logic                  sck_q;       // slave clock edge detect
	logic                  on, spi_mode, master, slave, run;
	logic                  tick, div_tick, m_cap, s_cap, cap;
	logic                  s_sel, slv_busy, busy, abort, start, done_set;
	logic                  cap_rise, wr_go, rd_go, we;
	logic                  wr_mode, wr_fmt, wr_data, wr_clr, collide;
	logic [5:0]            half;
	logic [2:0]            status;
	logic [31:0]           next_rdata;
	logic                  next_hit;
	// ************************************
	// mode decode
	// ************************************
	// i2c_debounce_select is stored only, nothing reads it here
	assign on       = mc.serial_module_enable;
	assign spi_mode = !mc.uart_select && mc.serial_op_mode <= serial_pkg::OP_SLAVE; // RULE1 RULE2 RULE6 RULE13
	assign master   = spi_mode && mc.serial_op_mode != serial_pkg::OP_SLAVE; // RULE3 RULE4
	assign slave    = spi_mode && mc.serial_op_mode == serial_pkg::OP_SLAVE; // RULE5
	assign run      = st == serial_pkg::ST_RUN;
	assign cap_rise = !(fc.clock_idle_level ^ fc.clock_edge_select);
	assign status   = {fc.write_collision_flag, mc.spi_incomplete_flag, fc.transfer_done_flag};
	assign irq      = |(status & irq_en);
	// ************************************
	// master clock sources
	// ************************************
	always_comb begin
		unique case (mc.serial_op_mode)
			serial_pkg::OP_DIV4:  half = serial_pkg::HALF4; // RULE3
			serial_pkg::OP_DIV16: half = serial_pkg::HALF16;
			default:              half = serial_pkg::HALF64;
		endcase
	end
	assign div_tick = div_cnt == half - 6'h01;
	// one tick per clock half period
	always_comb begin
		unique case (mc.serial_op_mode)
			serial_pkg::OP_SUB: tick = sub_clock ^ sub_q; // RULE4
			serial_pkg::OP_TMR: tick = timer_match;       // RULE4
			serial_pkg::OP_DIV4, serial_pkg::OP_DIV16, serial_pkg::OP_DIV64: tick = div_tick;
			default:            tick = 1'b0;
		endcase
	end
	// divider runs only during a transfer
	always_ff @(posedge mclk) begin
		if (!reset_n || !run || div_tick)
			div_cnt <= 6'h00; // RULE18
		else
			div_cnt <= div_cnt + 6'h01;
	end
	// edge detectors on synchronous inputs
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sub_q <= 1'b0;
			sck_q <= 1'b0;
		end else begin
			sub_q <= sub_clock;
			sck_q <= sck_i;
		end
	end
	// ************************************
	// master transfer
	// ************************************
	assign start = wr_data && !busy && on && master; // RULE7 RULE10
	assign m_cap = run && tick && (!sck_lvl == cap_rise);
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st       <= serial_pkg::ST_IDLE;
			edge_cnt <= 5'h00;
			sck_lvl  <= 1'b1;
		end else if (!run) begin
			// clock parked at idle level
			sck_lvl  <= !fc.clock_idle_level; // RULE18
			edge_cnt <= 5'h00;
			if (start)
				st <= serial_pkg::ST_RUN; // RULE7
		end else if (!on || !master) begin
			st <= serial_pkg::ST_IDLE; // RULE15
		end else if (tick) begin
			sck_lvl  <= !sck_lvl; // RULE18
			edge_cnt <= edge_cnt + 5'h01;
			if (edge_cnt == 5'(2 * BITS - 1))
				st <= serial_pkg::ST_IDLE; // RULE17
		end
	end
	// ************************************
	// slave transfer
	// ************************************
	assign s_sel    = on && slave && (!fc.select_pin_enable || !slave_select_n_i); // RULE9
	assign s_cap    = s_sel && (cap_rise ? (sck_i && !sck_q) : (!sck_i && sck_q)); // RULE7
	assign slv_busy = bit_cnt != 4'h0;
	assign abort    = on && slave && fc.select_pin_enable && slave_select_n_i && slv_busy; // RULE16
	always_ff @(posedge mclk) begin
		if (!reset_n || !on || !slave || abort)
			bit_cnt <= 4'h0;
		else if (s_cap)
			bit_cnt <= (bit_cnt == 4'(BITS - 1)) ? 4'h0 : bit_cnt + 4'h1; // RULE17
	end
	assign busy     = run || slv_busy;
	assign cap      = m_cap || s_cap;
	assign done_set = (run && tick && edge_cnt == 5'(2 * BITS - 1)) || (s_cap && bit_cnt == 4'(BITS - 1)) || abort;
	// ************************************
	// shift register
	// ************************************
	// software load when idle, else shift on capture edge
	always_ff @(posedge mclk) begin
		if (!reset_n)
			sh <= 8'h00;
		else if (wr_data && !busy)
			sh <= wdata[7:0]; // RULE10
		else if (cap && fc.bit_order_select)
			sh <= {sh[6:0], sdi}; // RULE8 RULE11
		else if (cap)
			sh <= {sdi, sh[7:1]}; // RULE8 RULE11
	end
	// ************************************
	// pins
	// ************************************
	assign sck_o             = sck_lvl;
	assign sck_oe            = on && master; // RULE7 RULE15
	assign sdo               = fc.bit_order_select ? sh[7] : sh[0]; // RULE8
	assign sdo_oe            = on && spi_mode; // RULE15
	assign slave_select_n_o  = !run;
	assign slave_select_n_oe = on && master && fc.select_pin_enable; // RULE9
	// ************************************
	// bus slave
	// ************************************
	assign wr_go   = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign we      = wr_go && wstrb[0];
	assign wr_mode = we && awaddr == serial_pkg::OFF_MODE;
	assign wr_fmt  = we && awaddr == serial_pkg::OFF_FMT && spi_mode; // RULE12
	assign wr_data = we && awaddr == serial_pkg::OFF_DATA && spi_mode; // RULE12
	assign wr_clr  = we && awaddr == serial_pkg::OFF_CLR;
	assign collide = wr_data && busy;
	// write response
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp  <= serial_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= (awaddr <= serial_pkg::OFF_IEN && awaddr[1:0] == 2'h0) ?
			          serial_pkg::RESP_OKAY : serial_pkg::RESP_SLV;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// control registers, hardware set wins over any clear
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			mc     <= serial_pkg::MODE_RST;
			fc     <= serial_pkg::FMT_RST;
			irq_en <= 3'h0;
		end else begin
			if (wr_mode)
				mc <= wdata[7:0]; // RULE1 RULE15
			if (wr_fmt)
				fc <= wdata[7:0];
			if (we && awaddr == serial_pkg::OFF_IEN)
				irq_en <= wdata[2:0];
			if (abort)
				mc.spi_incomplete_flag <= 1'b1; // RULE16
			else if (wr_clr && wdata[serial_pkg::ST_INC])
				mc.spi_incomplete_flag <= 1'b0;
			if (done_set)
				fc.transfer_done_flag <= 1'b1; // RULE16 RULE17
			else if (wr_clr && wdata[serial_pkg::ST_DONE])
				fc.transfer_done_flag <= 1'b0;
			if (collide)
				fc.write_collision_flag <= 1'b1;
			else if (wr_clr && wdata[serial_pkg::ST_COL])
				fc.write_collision_flag <= 1'b0;
		end
	end
	// read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_hit   = 1'b1;
		unique case (araddr)
			serial_pkg::OFF_MODE: next_rdata[7:0] = mc;
			serial_pkg::OFF_FMT:  next_rdata[7:0] = spi_mode ? fc : 8'h00; // RULE12
			serial_pkg::OFF_DATA: next_rdata[7:0] = spi_mode ? sh : 8'h00; // RULE11 RULE12
			serial_pkg::OFF_STAT: next_rdata[2:0] = status;
			serial_pkg::OFF_CLR:  next_rdata      = 32'h0000_0000;
			serial_pkg::OFF_IEN:  next_rdata[2:0] = irq_en;
			default:              next_hit        = 1'b0;
		endcase
	end
	assign rd_go   = arvalid && !rvalid;
	assign arready = rd_go;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= serial_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= next_hit ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLV;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	// ************************************
	// assertions
	// ************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// two system clocks per half period
	sequence half_step;
		$changed(sck_o) ##1 $stable(sck_o) ##1 $changed(sck_o);
	endsequence
	div4_rate_a: assert property (run && tick && mc.serial_op_mode == serial_pkg::OP_DIV4 // RULE3
		&& edge_cnt < 5'h0e && on |=> half_step) else $error("div4 clock rate wrong");
	uart_quiet_a: assert property (mc.uart_select |-> !sck_oe && !sdo_oe) // RULE2
		else $error("pins driven in uart mode");
	// pins let go at once; an enable written at this edge may drive them next cycle
	off_quiet_a: assert property (!on |-> (!sck_oe && !sdo_oe) ##1 !run) // RULE15
		else $error("interface active while off");
	clk_idle_a: assert property ($past(st) == serial_pkg::ST_IDLE |-> sck_o == !$past(fc.clock_idle_level)) // RULE18
		else $error("clock moved outside transfer");
	start_run_a: assert property (start |=> run) // RULE7
		else $error("write did not start transfer");
	slave_clk_a: assert property (slave |-> !sck_oe) // RULE7
		else $error("slave drives clock");
	eight_bits_a: assert property ($fell(run) && $past(on) && $past(master) |-> // RULE17
		$past(edge_cnt) == 5'(2 * BITS - 1) && fc.transfer_done_flag) else $error("transfer length wrong");
	ss_abort_a: assert property (abort |=> mc.spi_incomplete_flag && fc.transfer_done_flag && bit_cnt == 4'h0) // RULE16
		else $error("early deselect not flagged");
	// a software load while idle outranks a first slave capture edge
	rx_shift_a: assert property (cap && !(wr_data && !busy) && fc.bit_order_select |=> sh[0] == $past(sdi)) // RULE8
		else $error("input bit not captured");
endmodule

// >>> logic/serial_pkg.sv
package serial_pkg;
	// ************************************
	// register map (byte addresses)
	// ************************************
	localparam int            ADDR_W     = 5;
	localparam logic [4:0]    OFF_MODE   = 5'h00; // serial_mode_control
	localparam logic [4:0]    OFF_FMT    = 5'h04; // spi_format_control
	localparam logic [4:0]    OFF_DATA   = 5'h08; // serial_shift_data
	localparam logic [4:0]    OFF_STAT   = 5'h0c; // event status, read only
	localparam logic [4:0]    OFF_CLR    = 5'h10; // event clear, write only
	localparam logic [4:0]    OFF_IEN    = 5'h14; // event enable
	localparam logic [7:0]    MODE_RST   = 8'he0; // mode field 111 at reset
	localparam logic [7:0]    FMT_RST    = 8'h00;
	localparam logic [1:0]    RESP_OKAY  = 2'h0;
	localparam logic [1:0]    RESP_SLV   = 2'h2;
	// status bit positions
	localparam int            ST_DONE    = 0;
	localparam int            ST_INC     = 1;
	localparam int            ST_COL     = 2;
	// ************************************
	// operating modes and clock ratios
	// ************************************
	localparam logic [2:0]    OP_DIV4    = 3'h0;
	localparam logic [2:0]    OP_DIV16   = 3'h1;
	localparam logic [2:0]    OP_DIV64   = 3'h2;
	localparam logic [2:0]    OP_SUB     = 3'h3;
	localparam logic [2:0]    OP_TMR     = 3'h4;
	localparam logic [2:0]    OP_SLAVE   = 3'h5;
	localparam int            SYS_DIV4   = 4;
	localparam int            SYS_DIV16  = 16;
	localparam int            SYS_DIV64  = 64;
	localparam logic [5:0]    HALF4      = 6'(SYS_DIV4 / 2);
	localparam logic [5:0]    HALF16     = 6'(SYS_DIV16 / 2);
	localparam logic [5:0]    HALF64     = 6'(SYS_DIV64 / 2);
	// ************************************
	// register layouts
	// ************************************
	typedef struct packed {
		logic [2:0] serial_op_mode;
		logic       uart_select;
		logic [1:0] i2c_debounce_select;
		logic       serial_module_enable;
		logic       spi_incomplete_flag;
	} mode_ctl_s;
	typedef struct packed {
		logic [1:0] spare;
		logic       clock_idle_level;
		logic       clock_edge_select;
		logic       bit_order_select;
		logic       select_pin_enable;
		logic       write_collision_flag;
		logic       transfer_done_flag;
	} fmt_ctl_s;
	typedef enum logic {ST_IDLE, ST_RUN} xfer_e;
endpackage

// >>> verif/spi_far_end.sv
`timescale 1ns/1ps
// ************************************
// far-side spi slave, msb first
// ************************************
module spi_far_end (
	input  wire logic       sck,
	input  wire logic       ss_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output      logic       miso,
	output      logic [7:0] rx
);
	logic [7:0] tx   = 8'h00; // outgoing shift
	logic       last = 1'b0;  // last bit driven
	// reload at select, remember last bit at release
	always @(negedge ss_n) tx <= tx_byte;
	always @(posedge ss_n) last <= tx[7];
	// sample master data while our bit stands
	always @(negedge sck) begin
		if (!ss_n) rx <= {rx[6:0], mosi};
	end
	// next bit only after master's capture edge
	always @(posedge sck) begin
		if (!ss_n) tx <= {tx[6:0], 1'b0};
	end
	// released line shows the inverse of the last bit
	assign miso = ss_n ? ~last : tx[7];
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ************************************
	// stimulus and wires
	// ************************************
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  awaddr = 5'h00;
	logic [4:0]  araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        sub_clock = 1'b0;
	logic        timer_match = 1'b0;
	logic        sck_i = 1'b1;
	logic        ss_in = 1'b1;
	logic [7:0]  far_tx = 8'h3c;
	wire logic   awready, wready, bvalid, arready, rvalid, irq, sdi;
	wire logic   sck_o, sck_oe, sdo, sdo_oe, ss_o, ss_oe;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  far_rx;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	logic [31:0] rd;
	logic [1:0]  rsp;
	// pull-ups on released clock and select
	wire logic   sck_w = sck_oe ? sck_o : 1'b1;
	wire logic   ss_w = ss_oe ? ss_o : 1'b1;
	always #50 mclk = ~mclk;
	serial_spi i_dut (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sub_clock(sub_clock), .timer_match(timer_match), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .slave_select_n_i(ss_in),
		.slave_select_n_o(ss_o), .slave_select_n_oe(ss_oe), .irq(irq));
	spi_far_end i_far (.sck(sck_w), .ss_n(ss_w), .mosi(sdo), .tx_byte(far_tx), .miso(sdi),
		.rx(far_rx));
	// ************************************
	// bus and check tasks
	// ************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge mclk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge mclk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [4:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// ************************************
	// scenarios
	// ************************************
	task automatic t_access;
		rdr(serial_pkg::OFF_MODE);
		chk("mode reset", serial_pkg::MODE_RST, rd);
		chk("read resp", serial_pkg::RESP_OKAY, rsp);
		wr(serial_pkg::OFF_FMT, 8'h08);
		chk("write resp", serial_pkg::RESP_OKAY, rsp);
		rdr(serial_pkg::OFF_FMT);
		chk("format outside spi", 0, rd);
		rdr(5'h18);
		chk("unmapped resp", serial_pkg::RESP_SLV, rsp);
		chk("unmapped data", 0, rd);
		wr(5'h18, 8'h00);
		chk("unmapped write resp", serial_pkg::RESP_SLV, rsp);
		chk("clock oe off", 0, sck_oe);
		wr(serial_pkg::OFF_MODE, 8'h12);
		wr(serial_pkg::OFF_DATA, 8'h55);
		rdr(serial_pkg::OFF_DATA);
		chk("data in uart", 0, rd);
		chk("uart clock oe", 0, sck_oe);
		wr(serial_pkg::OFF_MODE, 8'h0e);
		chk("debounce master oe", 1, sck_oe & sdo_oe);
		rdr(serial_pkg::OFF_FMT);
		chk("format write kept out", 0, rd);
		rdr(serial_pkg::OFF_DATA);
		chk("uart data write kept out", 0, rd);
		wr(serial_pkg::OFF_MODE, 8'h0c);
		chk("disabled oe", 0, sck_oe | sdo_oe);
		wr(serial_pkg::OFF_MODE, 8'hc2);
		chk("i2c clock oe", 0, sck_oe);
		$display("test access done");
	endtask
	task automatic t_master;
		int n;
		int tg;
		int dv;
		logic s;
		wr(serial_pkg::OFF_MODE, 8'h02);
		wr(serial_pkg::OFF_FMT, 8'h0c);
		chk("select oe", 1, ss_oe);
		wr(serial_pkg::OFF_IEN, 8'h01);
		for (int m = 0; m < 3; m++) begin
			dv = 4 << (2 * m);
			far_tx <= 8'h3c ^ m[7:0];
			wr(serial_pkg::OFF_MODE, {m[2:0], 5'h02});
			wr(serial_pkg::OFF_DATA, 8'ha5 + m[7:0]);
			n = 0;
			tg = 0;
			s = sck_o;
			while (irq !== 1'b1) begin
				@(posedge mclk);
				n++;
				if (sck_o !== s) tg++;
				s = sck_o;
			end
			chk("clock ratio", 1, n >= 8 * dv - 4 && n <= 8 * dv + 4);
			chk("clock toggles", 16, tg);
			chk("far side rx", 8'ha5 + m[7:0], far_rx);
			rdr(serial_pkg::OFF_DATA);
			chk("rx data", 8'h3c ^ m[7:0], rd);
			wr(serial_pkg::OFF_CLR, 8'h07);
			chk("irq cleared", 0, irq);
		end
		wr(serial_pkg::OFF_IEN, 8'h00);
		far_tx <= 8'h96;
		wr(serial_pkg::OFF_MODE, 8'h02);
		wr(serial_pkg::OFF_DATA, 8'h5a);
		wr(serial_pkg::OFF_DATA, 8'h77);
		repeat (40) @(posedge mclk);
		chk("irq masked", 0, irq);
		rdr(serial_pkg::OFF_STAT);
		chk("collision status", 8'h05, rd);
		rdr(serial_pkg::OFF_DATA);
		chk("data kept", 8'h96, rd);
		wr(serial_pkg::OFF_CLR, 8'h07);
		$display("test master done");
	endtask
	task automatic t_sources;
		for (int k = 0; k < 2; k++) begin
			far_tx <= 8'hc3 ^ k[7:0];
			wr(serial_pkg::OFF_MODE, (k == 0) ? 8'h62 : 8'h82);
			wr(serial_pkg::OFF_DATA, 8'h81 ^ k[7:0]);
			repeat (10) @(posedge mclk);
			chk("clock idle", 1, sck_o);
			repeat (16) begin
				repeat (3) @(posedge mclk);
				if (k == 0) sub_clock <= ~sub_clock;
				else timer_match <= 1'b1;
				@(posedge mclk);
				timer_match <= 1'b0;
			end
			repeat (4) @(posedge mclk);
			rdr(serial_pkg::OFF_STAT);
			chk("source done", 1, rd);
			chk("source far rx", 8'h81 ^ k[7:0], far_rx);
			wr(serial_pkg::OFF_CLR, 8'h07);
		end
		$display("test sources done");
	endtask
	task automatic t_slave;
		wr(serial_pkg::OFF_MODE, 8'ha2);
		wr(serial_pkg::OFF_FMT, 8'h04);
		chk("slave clock oe", 0, sck_oe);
		@(posedge mclk);
		ss_in <= 1'b0;
		repeat (3) @(posedge mclk);
		sck_i <= 1'b0;
		repeat (3) @(posedge mclk);
		sck_i <= 1'b1;
		repeat (3) @(posedge mclk);
		ss_in <= 1'b1;
		repeat (3) @(posedge mclk);
		rdr(serial_pkg::OFF_MODE);
		chk("incomplete flag", 8'ha3, rd);
		rdr(serial_pkg::OFF_STAT);
		chk("abort status", 8'h03, rd);
		$display("test slave done");
	endtask
	// ************************************
	// verdict, timeout and main sequence
	// ************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		t_access();
		t_master();
		t_sources();
		t_slave();
		tally_and_finish();
	end
endmodule
